// >>> rtl/dcwa_pkg.sv
package dcwa_pkg;
  localparam logic [7:0] CMD_NOP = 8'h00;
  localparam logic [7:0] CMD_GET_DISP_MODE = 8'h0D;
  localparam logic [7:0] CMD_GET_SIG_MODE = 8'h0E;
  localparam logic [7:0] CMD_SLEEP_IN = 8'h10;
  localparam logic [7:0] CMD_SLEEP_OUT = 8'h11;
  localparam logic [7:0] CMD_PARTIAL = 8'h12;
  localparam logic [7:0] CMD_NORMAL = 8'h13;
  localparam logic [7:0] CMD_INV_OFF = 8'h20;
  localparam logic [7:0] CMD_INV_ON = 8'h21;
  localparam logic [7:0] CMD_GAMMA = 8'h26;
  localparam logic [7:0] CMD_DISP_OFF = 8'h28;
  localparam logic [7:0] CMD_DISP_ON = 8'h29;
  localparam logic [7:0] CMD_COL = 8'h2A;
  localparam logic [7:0] CMD_PAGE = 8'h2B;
  localparam logic [7:0] CMD_WR_START = 8'h2C;
  localparam logic [7:0] CMD_RD_START = 8'h2E;
  localparam logic [3:0] GAMMA_CODE_RESET = 4'h8;
  localparam logic [3:0] GAMMA_CODE_NONE = 4'h0;
  localparam logic [3:0] GAMMA_CODE_C0 = 4'h1;
  localparam logic [3:0] GAMMA_CODE_C1 = 4'h2;
  localparam logic [3:0] GAMMA_CODE_C2 = 4'h4;
  localparam logic [3:0] GAMMA_CODE_C3 = 4'h8;
  localparam logic [1:0] GAMMA_PINS_RESET = 2'h3;
  localparam int DISP_SCROLL_BIT = 7;
  localparam int DISP_INVERT_BIT = 5;
  localparam int SIG_TEAR_BIT = 7;
  localparam logic [15:0] EXTENT_RESET = 16'h0000;
  localparam logic [1:0] PARAM_LAST = 2'h3;
  typedef enum logic [3:0]
  {
    DCWA_IDLE = 4'b0001,
    DCWA_PARAM = 4'b0010,
    DCWA_WRITE = 4'b0100,
    DCWA_READ = 4'b1000
  } dcwa_mode_t;
endpackage

// >>> rtl/dcwa_frame_mem.sv
module dcwa_frame_mem #(
  parameter int ADDR_W = 8,
  parameter int DATA_W = 8
) (
  input wire logic clk_sys_in,
  input wire logic wr_en_in,
  input wire logic [ADDR_W-1:0] addr_in,
  input wire logic [DATA_W-1:0] wr_data_in,
  output logic [DATA_W-1:0] rd_data_out
);
  logic [DATA_W-1:0] mem [2**ADDR_W];

  initial
  begin
    if (ADDR_W < 1 || ADDR_W > 20 || DATA_W < 1)
    begin
      $error("dcwa_frame_mem: bad geometry");
    end
  end

  // registered read; the array holds no reset to allow block ram
  always_ff @(posedge clk_sys_in)
  begin
    if (wr_en_in)
    begin
      mem[addr_in] <= wr_data_in;
    end
    rd_data_out <= mem[addr_in];
  end
endmodule

// >>> rtl/dcwa_top.sv
// Behaviour
// - display-mode query returns scroll bit7, invert bit5, gamma bits 2:0
// - reported gamma resets to 011; codes 000..011 mean curves 0..3
// - signal-mode query returns tearing enable in bit7, reset zero
// - sleep entry blanks panel, drives io pin zero low unless repurposed
// - sleep exit wakes panel, drives io pin zero high unless repurposed
// - partial command enters partial mode; only normal command leaves it
// - normal command clears partial display, and vertical scrolling unless a scroll request rises in that cycle
// - invert exit stops panel-path inversion, frame buffer untouched
// - invert entry inverts panel-path pixels only, frame buffer untouched
// - gamma code one-hot or 0000, reset 1000, maps to two select pins
// - display off blanks panel, frame buffer untouched
// - display on shows frame buffer image again
// - column command takes four bytes, high first, bounds host transfers
// - page command takes four bytes, high first, both reset zero
// - write start reloads counters to start and stores first pixel there
// - order bit 0: columns step first, then page, end at last cell
// - order bit 1: pages step first, then column, end at last cell
// - write pixels beyond the window size are discarded
// - read start reloads counters, returns pixels in same traversal order
// - no-operation only ends an ongoing transfer
module dcwa_top
  import dcwa_pkg::*;
#(
  parameter int COORD_W = 4,
  parameter int PIXEL_W = 8
) (
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  input wire logic wr_strobe_in,
  input wire logic rd_strobe_in,
  input wire logic data_sel_in,
  input wire logic [PIXEL_W-1:0] wr_data_in,
  output logic [PIXEL_W-1:0] rd_data_out,
  output logic rd_valid_out,
  input wire logic page_col_order_in,
  input wire logic scroll_active_in,
  input wire logic tear_enable_in,
  input wire logic io_zero_repurposed_in,
  output logic [1:0] gamma_select_pins_out,
  output logic general_io_pin_zero_out,
  output logic panel_awake_out,
  output logic display_enable_out,
  output logic partial_mode_out,
  output logic scroll_enable_out,
  output logic invert_out,
  output logic [15:0] start_column_out,
  output logic [15:0] end_column_out,
  output logic [15:0] start_page_out,
  output logic [15:0] end_page_out,
  output logic transfer_active_out
);
  import dcwa_pkg::*;

  localparam int ADDR_W = 2 * COORD_W;

  initial
  begin
    if (COORD_W < 1 || COORD_W > 10 || PIXEL_W < 8)
    begin
      $error("dcwa_top: unsupported parameters");
    end
  end

  typedef struct packed {
    dcwa_mode_t mode;
    logic [7:0] cmd;
    logic [1:0] pidx;
    logic [7:0] hold;
    logic [3:0] gamma_code;
    logic [1:0] gamma_pins;
    logic io_zero;
    logic awake;
    logic disp_on;
    logic partial;
    logic scroll_en;
    logic scroll_seen;
    logic invert;
    logic [15:0] start_column;
    logic [15:0] end_column;
    logic [15:0] start_page;
    logic [15:0] end_page;
    logic [15:0] col;
    logic [15:0] page;
    logic done;
    logic rd_pending;
    logic [PIXEL_W-1:0] rd_data;
    logic rd_valid;
  } dcwa_state_t;

  dcwa_state_t st;
  dcwa_state_t next_st;

  logic mem_wr;
  logic [ADDR_W-1:0] mem_addr;
  logic [PIXEL_W-1:0] mem_rd;
  logic last_cell;
  logic col_at_end;
  logic page_at_end;
  logic cmd_byte;
  logic data_byte;

  assign cmd_byte = wr_strobe_in && !data_sel_in;
  assign data_byte = wr_strobe_in && data_sel_in;
  assign col_at_end = st.col == st.end_column;
  assign page_at_end = st.page == st.end_page;
  assign last_cell = col_at_end && page_at_end;
  assign mem_addr = {st.page[COORD_W-1:0], st.col[COORD_W-1:0]};
  // discarded pixels never reach the array
  assign mem_wr = st.mode == DCWA_WRITE && data_byte && !st.done;

  dcwa_frame_mem #(
    .ADDR_W(ADDR_W),
    .DATA_W(PIXEL_W)
  ) u_mem (
    .clk_sys_in(clk_sys_in),
    .wr_en_in(mem_wr),
    .addr_in(mem_addr),
    .wr_data_in(wr_data_in),
    .rd_data_out(mem_rd)
  );

  always_comb
  begin
    next_st = st;
    next_st.rd_valid = 1'b0;
    // a read request launches the array access; data land on the next edge
    if (st.rd_pending)
    begin
      next_st.rd_pending = 1'b0;
      next_st.rd_valid = 1'b1;
      next_st.rd_data = mem_rd;
    end
    if (cmd_byte)
    begin
      next_st.mode = DCWA_IDLE;
      next_st.cmd = wr_data_in[7:0];
      next_st.pidx = 2'h0;
      next_st.done = 1'b0;
      next_st.rd_pending = 1'b0;
      unique case (wr_data_in[7:0])
        CMD_GET_DISP_MODE,
        CMD_GET_SIG_MODE,
        CMD_GAMMA,
        CMD_COL,
        CMD_PAGE:
        begin
          next_st.mode = DCWA_PARAM;
        end
        CMD_SLEEP_IN:
        begin
          next_st.awake = 1'b0;
          if (!io_zero_repurposed_in)
            next_st.io_zero = 1'b0;
        end
        CMD_SLEEP_OUT:
        begin
          next_st.awake = 1'b1;
          if (!io_zero_repurposed_in)
            next_st.io_zero = 1'b1;
        end
        CMD_PARTIAL: next_st.partial = 1'b1;
        CMD_NORMAL:
        begin
          next_st.partial = 1'b0;
          next_st.scroll_en = 1'b0;
        end
        CMD_INV_OFF: next_st.invert = 1'b0;
        CMD_INV_ON: next_st.invert = 1'b1;
        CMD_DISP_OFF: next_st.disp_on = 1'b0;
        CMD_DISP_ON: next_st.disp_on = 1'b1;
        CMD_WR_START:
        begin
          next_st.mode = DCWA_WRITE;
          next_st.col = st.start_column;
          next_st.page = st.start_page;
        end
        CMD_RD_START:
        begin
          next_st.mode = DCWA_READ;
          next_st.col = st.start_column;
          next_st.page = st.start_page;
        end
        default: next_st.mode = DCWA_IDLE;
      endcase
    end
    else
    begin
      unique case (st.mode)
        DCWA_IDLE: next_st.mode = DCWA_IDLE;
        DCWA_PARAM:
        begin
          if (data_byte)
          begin
            next_st.pidx = st.pidx + 2'h1;
            next_st.hold = wr_data_in[7:0];
            unique case (st.cmd)
              CMD_GAMMA:
              begin
                next_st.mode = DCWA_IDLE;
                next_st.gamma_code = wr_data_in[3:0];
                unique case (wr_data_in[3:0])
                  GAMMA_CODE_NONE: next_st.gamma_pins = 2'h0;
                  GAMMA_CODE_C0: next_st.gamma_pins = 2'h0;
                  GAMMA_CODE_C1: next_st.gamma_pins = 2'h1;
                  GAMMA_CODE_C2: next_st.gamma_pins = 2'h2;
                  GAMMA_CODE_C3: next_st.gamma_pins = 2'h3;
                  default: next_st.gamma_code = st.gamma_code;
                endcase
              end
              CMD_COL:
              begin
                unique case (st.pidx)
                  2'h1: next_st.start_column = {st.hold, wr_data_in[7:0]};
                  2'h3: next_st.end_column = {st.hold, wr_data_in[7:0]};
                  default: next_st.hold = wr_data_in[7:0];
                endcase
                if (st.pidx == PARAM_LAST)
                  next_st.mode = DCWA_IDLE;
              end
              CMD_PAGE:
              begin
                unique case (st.pidx)
                  2'h1: next_st.start_page = {st.hold, wr_data_in[7:0]};
                  2'h3: next_st.end_page = {st.hold, wr_data_in[7:0]};
                  default: next_st.hold = wr_data_in[7:0];
                endcase
                if (st.pidx == PARAM_LAST)
                  next_st.mode = DCWA_IDLE;
              end
              default: next_st.mode = DCWA_IDLE;
            endcase
          end
          if (rd_strobe_in && data_sel_in)
          begin
            // query answer is one byte, then the command is spent
            next_st.rd_valid = 1'b1;
            next_st.mode = DCWA_IDLE;
            next_st.rd_data = '0;
            if (st.cmd == CMD_GET_DISP_MODE)
            begin
              next_st.rd_data[DISP_SCROLL_BIT] = scroll_active_in;
              next_st.rd_data[DISP_INVERT_BIT] = st.invert;
              next_st.rd_data[2:0] = {1'b0, st.gamma_pins};
            end
            else if (st.cmd == CMD_GET_SIG_MODE)
            begin
              next_st.rd_data[SIG_TEAR_BIT] = tear_enable_in;
            end
          end
        end
        DCWA_WRITE, DCWA_READ:
        begin
          if ((st.mode == DCWA_WRITE && data_byte) ||
              (st.mode == DCWA_READ && rd_strobe_in && data_sel_in &&
               !st.done))
          begin
            next_st.rd_pending = st.mode == DCWA_READ;
            if (last_cell || st.done)
            begin
              next_st.done = 1'b1;
            end
            else if (!page_col_order_in)
            begin
              if (col_at_end)
              begin
                next_st.col = st.start_column;
                next_st.page = st.page + 16'h0001;
              end
              else
              begin
                next_st.col = st.col + 16'h0001;
              end
            end
            else
            begin
              if (page_at_end)
              begin
                next_st.page = st.start_page;
                next_st.col = st.col + 16'h0001;
              end
              else
              begin
                next_st.page = st.page + 16'h0001;
              end
            end
          end
        end
      endcase
    end
    // a rising scroll request arms scrolling; set beats a same-cycle clear
    next_st.scroll_seen = scroll_active_in;
    if (scroll_active_in && !st.scroll_seen)
      next_st.scroll_en = 1'b1;
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (!rst_n_in)
    begin
      st <= '0;
      st.mode <= DCWA_IDLE;
      st.gamma_code <= GAMMA_CODE_RESET;
      st.gamma_pins <= GAMMA_PINS_RESET;
      st.start_column <= EXTENT_RESET;
      st.end_column <= EXTENT_RESET;
      st.start_page <= EXTENT_RESET;
      st.end_page <= EXTENT_RESET;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign rd_data_out = st.rd_data;
  assign rd_valid_out = st.rd_valid;
  assign gamma_select_pins_out = st.gamma_pins;
  assign general_io_pin_zero_out = st.io_zero;
  // blanking and inversion act only on the panel side, never the array
  assign panel_awake_out = st.awake;
  assign display_enable_out = st.disp_on;
  assign partial_mode_out = st.partial;
  assign scroll_enable_out = st.scroll_en;
  assign invert_out = st.invert;
  assign start_column_out = st.start_column;
  assign end_column_out = st.end_column;
  assign start_page_out = st.start_page;
  assign end_page_out = st.end_page;
  assign transfer_active_out = (st.mode == DCWA_WRITE ||
                                st.mode == DCWA_READ) && !st.done;
endmodule

// >>> testbench/dcwa_asserts.sv
module dcwa_asserts #(
  parameter int PIXEL_W = 8
) (
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  input wire logic wr_strobe_in,
  input wire logic rd_strobe_in,
  input wire logic data_sel_in,
  input wire logic [PIXEL_W-1:0] wr_data_in,
  input wire logic [PIXEL_W-1:0] rd_data_out,
  input wire logic rd_valid_out,
  input wire logic scroll_active_in,
  input wire logic tear_enable_in,
  input wire logic io_zero_repurposed_in,
  input wire logic [1:0] gamma_select_pins_out,
  input wire logic general_io_pin_zero_out,
  input wire logic panel_awake_out,
  input wire logic display_enable_out,
  input wire logic partial_mode_out,
  input wire logic scroll_enable_out,
  input wire logic invert_out,
  input wire logic transfer_active_out
);
  timeunit 1ns;
  timeprecision 1ps;
  import dcwa_pkg::*;
  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (!rst_n_in);
  sequence s_cmd(logic [7:0] c);
    wr_strobe_in && !data_sel_in && wr_data_in[7:0] == c;
  endsequence
  sequence s_dat(logic [7:0] v);
    wr_strobe_in && data_sel_in && wr_data_in[7:0] == v;
  endsequence
  sequence s_rd;
    rd_strobe_in && data_sel_in;
  endsequence
  a_disp_reply: assert property (
    s_cmd(CMD_GET_DISP_MODE) ##2 s_rd |=> rd_valid_out && rd_data_out ==
    {scroll_active_in, 1'h0, invert_out, 3'h0, gamma_select_pins_out})
    else $error("display mode reply wrong");
  a_sig_reply: assert property (
    s_cmd(CMD_GET_SIG_MODE) ##2 s_rd |=> rd_valid_out &&
    rd_data_out == {tear_enable_in, 7'h00})
    else $error("signal mode reply wrong");
  a_sleep_in: assert property (
    s_cmd(CMD_SLEEP_IN) ##0 !io_zero_repurposed_in
    |=> !general_io_pin_zero_out && !panel_awake_out)
    else $error("sleep entry did not lower io pin");
  a_sleep_out: assert property (
    s_cmd(CMD_SLEEP_OUT) ##0 !io_zero_repurposed_in
    |=> general_io_pin_zero_out && panel_awake_out)
    else $error("sleep exit did not raise io pin");
  a_io_kept: assert property (
    (s_cmd(CMD_SLEEP_IN) or s_cmd(CMD_SLEEP_OUT)) ##0 io_zero_repurposed_in
    |=> $stable(general_io_pin_zero_out))
    else $error("repurposed io pin was touched");
  a_partial_on: assert property (
    s_cmd(CMD_PARTIAL) |=> partial_mode_out)
    else $error("partial mode not entered");
  a_partial_hold: assert property (
    partial_mode_out && !(wr_strobe_in && !data_sel_in &&
    wr_data_in[7:0] == CMD_NORMAL) |=> partial_mode_out)
    else $error("partial mode left without normal command");
  a_normal_mode: assert property (
    s_cmd(CMD_NORMAL) |=> !partial_mode_out && !scroll_enable_out)
    else $error("normal mode left partial or scroll on");
  a_invert_on: assert property (
    s_cmd(CMD_INV_ON) |=> invert_out)
    else $error("invert not entered");
  a_disp_on: assert property (
    s_cmd(CMD_DISP_ON) |=> display_enable_out)
    else $error("display not enabled");
  a_gamma_pins: assert property (
    s_cmd(CMD_GAMMA) ##2 s_dat(8'h04) |=> gamma_select_pins_out == 2'h2)
    else $error("gamma pins wrong for curve two");
  a_gamma_resv: assert property (
    s_cmd(CMD_GAMMA) ##2 s_dat(8'h03) |=> $stable(gamma_select_pins_out))
    else $error("reserved gamma code changed pins");
  a_cmd_ends: assert property (
    wr_strobe_in && !data_sel_in && wr_data_in[7:0] != CMD_WR_START &&
    wr_data_in[7:0] != CMD_RD_START |=> !transfer_active_out)
    else $error("command did not end transfer");
endmodule

// >>> testbench/dcwa_host.sv
module dcwa_host #(
  parameter int SLEEP_WAIT = 20,
  parameter int WAKE_GAP = 40
) (
  input wire logic clk_sys_in,
  input wire logic [7:0] rd_data_in,
  input wire logic rd_valid_in,
  output logic wr_strobe_out,
  output logic rd_strobe_out,
  output logic data_sel_out,
  output logic [7:0] wr_data_out
);
  timeunit 1ns;
  timeprecision 1ps;
  import dcwa_pkg::*;
  initial
  begin
    wr_strobe_out = 1'h0;
    rd_strobe_out = 1'h0;
    data_sel_out = 1'h0;
    wr_data_out = 8'h00;
  end
  // idle cycle between accesses; released data inverted, not left stale
  task automatic put(input logic sel, input logic [7:0] b);
    @(posedge clk_sys_in);
    #1;
    wr_strobe_out = 1'h1;
    data_sel_out = sel;
    wr_data_out = b;
    @(posedge clk_sys_in);
    #1;
    wr_strobe_out = 1'h0;
    wr_data_out = ~b;
  endtask
  task automatic cmd(input logic [7:0] b);
    put(1'h0, b);
  endtask
  task automatic dat(input logic [7:0] b);
    put(1'h1, b);
  endtask
  // waits scaled down from milliseconds to keep the run short
  task automatic sleep(input logic [7:0] b);
    if (b == CMD_SLEEP_IN)
    begin
      repeat (WAKE_GAP) @(posedge clk_sys_in);
    end
    put(1'h0, b);
    repeat (SLEEP_WAIT) @(posedge clk_sys_in);
    #1;
  endtask
  task automatic rd(output logic [7:0] d);
    d = 'x;
    @(posedge clk_sys_in);
    #1;
    rd_strobe_out = 1'h1;
    data_sel_out = 1'h1;
    @(posedge clk_sys_in);
    #1;
    rd_strobe_out = 1'h0;
    for (int n = 0; n < 4; n++)
    begin
      if (rd_valid_in === 1'h1)
      begin
        d = rd_data_in;
        break;
      end
      @(posedge clk_sys_in);
      #1;
    end
  endtask
endmodule

// >>> testbench/dcwa_top_tb.sv
module dcwa_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import dcwa_pkg::*;
  logic clk_sys_in = 1'h0;
  logic rst_n_in = 1'h0;
  logic wr_strobe, rd_strobe, data_sel, rd_valid, io_zero, awake, disp_en;
  logic partial, scroll_en, inv, active;
  logic order = 1'h0, scroll = 1'h0, tear = 1'h0, repurp = 1'h0;
  logic [7:0] wr_data, rd_data, d;
  logic [1:0] gam;
  logic [15:0] sc, ec, sp, ep;
  logic [7:0] gcode [6] = '{8'h01, 8'h02, 8'h08, 8'h00, 8'h04, 8'h03};
  logic [1:0] gpin [6] = '{2'h0, 2'h1, 2'h3, 2'h0, 2'h2, 2'h2};
  int error_cnt = 0;
  int checks_done = 0;
  int cyc = 0;
  always #20 clk_sys_in = ~clk_sys_in;
  dcwa_top u_dut (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in),
    .wr_strobe_in(wr_strobe), .rd_strobe_in(rd_strobe),
    .data_sel_in(data_sel), .wr_data_in(wr_data), .rd_data_out(rd_data),
    .rd_valid_out(rd_valid), .page_col_order_in(order),
    .scroll_active_in(scroll), .tear_enable_in(tear),
    .io_zero_repurposed_in(repurp), .gamma_select_pins_out(gam),
    .general_io_pin_zero_out(io_zero), .panel_awake_out(awake),
    .display_enable_out(disp_en), .partial_mode_out(partial),
    .scroll_enable_out(scroll_en), .invert_out(inv),
    .start_column_out(sc), .end_column_out(ec), .start_page_out(sp),
    .end_page_out(ep), .transfer_active_out(active));
  dcwa_host h (.clk_sys_in(clk_sys_in), .rd_data_in(rd_data),
    .rd_valid_in(rd_valid), .wr_strobe_out(wr_strobe),
    .rd_strobe_out(rd_strobe), .data_sel_out(data_sel),
    .wr_data_out(wr_data));
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic finish_test();
    if (error_cnt == 0 && checks_done > 0)
    begin
      $display("Regression OK");
    end
    else
    begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // start never above end
  task automatic win(input logic [15:0] a, b, c, e);
    h.cmd(CMD_COL);
    h.dat(a[15:8]);
    h.dat(a[7:0]);
    h.dat(b[15:8]);
    h.dat(b[7:0]);
    h.cmd(CMD_PAGE);
    h.dat(c[15:8]);
    h.dat(c[7:0]);
    h.dat(e[15:8]);
    h.dat(e[7:0]);
  endtask
  task automatic read_back(input int mode);
    h.cmd(CMD_RD_START);
    for (int k = 0; k < 6; k++)
    begin
      h.rd(d);
      if (mode == 0)
        chk(64'(d), 64'(8'h10 + k));
      else if (mode == 1)
        chk(64'(d), 64'(8'h10 + (k % 2) * 3 + k / 2));
      else
        chk(64'(d), 64'(8'h20 + (k % 3) * 2 + k / 3));
    end
  endtask
  always @(posedge clk_sys_in)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      error_cnt++;
      finish_test();
    end
  end
  initial
  begin
    repeat (6) @(posedge clk_sys_in);
    #1;
    rst_n_in = 1'h1;
    chk(64'({gam, io_zero, awake, disp_en, partial, inv}), 64'h60);
    chk({sc, ec, sp, ep}, 64'h0);
    h.cmd(CMD_GET_DISP_MODE);
    h.rd(d);
    chk(64'(d), 64'h03);
    tear = 1'h1;
    h.cmd(CMD_GET_SIG_MODE);
    h.rd(d);
    chk(64'(d), 64'h80);
    for (int i = 0; i < 6; i++)
    begin
      h.cmd(CMD_GAMMA);
      h.dat(gcode[i]);
      chk(64'(gam), 64'(gpin[i]));
    end
    scroll = 1'h1;
    h.cmd(CMD_INV_ON);
    h.cmd(CMD_GET_DISP_MODE);
    h.rd(d);
    chk(64'(d), 64'hA2);
    h.sleep(CMD_SLEEP_OUT);
    chk(64'({io_zero, awake}), 64'h3);
    h.sleep(CMD_SLEEP_IN);
    chk(64'({io_zero, awake}), 64'h0);
    repurp = 1'h1;
    h.sleep(CMD_SLEEP_OUT);
    chk(64'({io_zero, awake}), 64'h1);
    h.cmd(CMD_PARTIAL);
    h.cmd(CMD_DISP_ON);
    chk(64'({partial, disp_en}), 64'h3);
    h.cmd(CMD_DISP_OFF);
    h.cmd(CMD_INV_OFF);
    chk(64'({partial, disp_en, inv, scroll_en}), 64'h9);
    h.cmd(CMD_NORMAL);
    chk(64'({partial, scroll_en}), 64'h0);
    win(16'h0002, 16'h0004, 16'h0001, 16'h0002);
    chk({sc, ec, sp, ep}, 64'h0002_0004_0001_0002);
    h.cmd(CMD_WR_START);
    for (int i = 0; i < 8; i++)
      h.dat(8'(8'h10 + i));
    read_back(0);
    order = 1'h1;
    h.cmd(CMD_INV_ON);
    read_back(1);
    h.cmd(CMD_WR_START);
    for (int i = 0; i < 6; i++)
      h.dat(8'(8'h20 + i));
    order = 1'h0;
    read_back(2);
    h.cmd(CMD_RD_START);
    h.rd(d);
    chk(64'(active), 64'h1);
    h.cmd(CMD_NOP);
    chk(64'(active), 64'h0);
    finish_test();
  end
endmodule
bind dcwa_top dcwa_asserts #(.PIXEL_W(PIXEL_W)) u_asserts (
  .clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in),
  .wr_strobe_in(wr_strobe_in), .rd_strobe_in(rd_strobe_in),
  .data_sel_in(data_sel_in), .wr_data_in(wr_data_in),
  .rd_data_out(rd_data_out), .rd_valid_out(rd_valid_out),
  .scroll_active_in(scroll_active_in), .tear_enable_in(tear_enable_in),
  .io_zero_repurposed_in(io_zero_repurposed_in),
  .gamma_select_pins_out(gamma_select_pins_out),
  .general_io_pin_zero_out(general_io_pin_zero_out),
  .panel_awake_out(panel_awake_out),
  .display_enable_out(display_enable_out),
  .partial_mode_out(partial_mode_out),
  .scroll_enable_out(scroll_enable_out), .invert_out(invert_out),
  .transfer_active_out(transfer_active_out));
